// ---- dv/sfp_host_model.sv ----
// Purpose: Behavioural host on the serial link of the sequencer.
// Assumes: Mode 0 framing, serial clock period of 160 ns.
// Notes:   Serial clock stands low between frames; data idles inverted.
module sfp_host_model (
   input wire logic core_clk,
   output logic chipSelN,
   output logic serialClk,
   output logic serialIn
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      chipSelN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
   end

   // Eight core clocks, so each half period is well above the minimum
   task automatic half();
      repeat (8) @(posedge core_clk);
      #1;
   endtask : half

   // Shifts the first nBits of a left-aligned frame, then deselects
   task automatic send(input logic [47:0] frame, input int nBits);
      @(posedge core_clk);
      #1;
      chipSelN = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         serialIn = frame[47-i];
         half();
         serialClk = 1'b1;
         half();
         serialClk = 1'b0;
      end
      half();
      // Released data line must not keep showing the last bit
      serialIn = ~serialIn;
      chipSelN = 1'b1;
      half();
   endtask : send
endmodule : sfp_host_model

// ---- dv/test_sfp_sequencer.sv ----
// Purpose: Self-checking bench of the flash command sequencer.
// Assumes: Erase time shortened to ERASE_N cycles.
// Notes:   Each frame leaves eight core clocks for the command to act.
module test_sfp_sequencer
   import sfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int ERASE_N = 300;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic chipSelN, serialClk, serialIn;
   logic writeProtectN = 1'b1;
   logic protectionLockBit = 1'b0;
   logic verifyFail = 1'b0;
   logic writeLatchFlag, busy, eraseProgramErrorFlag;
   logic [15:0] sectorProtect;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;

   sfp_host_model u_sfp_host_model (
      .core_clk(core_clk),
      .chipSelN(chipSelN),
      .serialClk(serialClk),
      .serialIn(serialIn)
   );

   sfp_sequencer #(.NUM_SECTORS(16), .ERASE_CYCLES(ERASE_N)) u_sfp_sequencer (
      .core_clk(core_clk),
      .rst(rst),
      .chipSelN(chipSelN),
      .serialClk(serialClk),
      .serialIn(serialIn),
      .writeProtectN(writeProtectN),
      .protectionLockBit(protectionLockBit),
      .verifyFail(verifyFail),
      .writeLatchFlag(writeLatchFlag),
      .busy(busy),
      .eraseProgramErrorFlag(eraseProgramErrorFlag),
      .sectorProtect(sectorProtect)
   );

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic cmd(input logic [7:0] op, input int n);
      u_sfp_host_model.send({op, 40'h0}, n);
   endtask : cmd

   // Upper address nibble is junk that the sector decode must ignore
   task automatic sect(input logic [7:0] op, input int s, input int n);
      u_sfp_host_model.send({op, 4'ha, 4'(s), 32'h0}, n);
   endtask : sect

   task automatic wait_idle(output int dur, input int t0);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      dur = cyc - t0;
   endtask : wait_idle

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check(writeLatchFlag, 0);
      check(busy, 0);
      check(eraseProgramErrorFlag, 0);
      check(sectorProtect, 16'hffff);
      $display("test reset done");
   endtask : t_reset

   task automatic t_latch();
      cmd(SFP_OP_WREN, 7);
      check(writeLatchFlag, 0);
      cmd(SFP_OP_WREN, 16);
      check(writeLatchFlag, 1);
      cmd(SFP_OP_WRDI, 9);
      check(writeLatchFlag, 1);
      cmd(SFP_OP_WRDI, 8);
      check(writeLatchFlag, 0);
      $display("test latch done");
   endtask : t_latch

   task automatic t_prot();
      logic [15:0] exp;
      cmd(SFP_OP_WREN, 8);
      cmd(SFP_OP_CE_A, 8);
      check(busy, 0);
      check(writeLatchFlag, 0);
      sect(SFP_OP_UNPROT, 5, 32);
      check(sectorProtect, 16'hffff);
      protectionLockBit = 1'b1;
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_UNPROT, 5, 32);
      check(writeLatchFlag, 0);
      check(sectorProtect, 16'hffff);
      writeProtectN = 1'b0;
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_UNPROT, 6, 32);
      check(sectorProtect, 16'hffff);
      writeProtectN = 1'b1;
      protectionLockBit = 1'b0;
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_UNPROT, 5, 24);
      check(writeLatchFlag, 0);
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_UNPROT, 5, 33);
      check(sectorProtect, 16'hffff);
      for (int i = 0; i < 16; i++) begin
         cmd(SFP_OP_WREN, 8);
         sect(SFP_OP_UNPROT, i, (i == 0) ? 40 : 32);
         exp = 16'hffff << (i + 1);
         check(sectorProtect, exp);
         check(writeLatchFlag, 0);
      end
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_PROT, 3, 32);
      check(sectorProtect, 16'h0008);
      check(writeLatchFlag, 0);
      cmd(SFP_OP_WREN, 8);
      cmd(SFP_OP_CE_B, 8);
      check(busy, 0);
      cmd(SFP_OP_WREN, 8);
      sect(SFP_OP_UNPROT, 3, 32);
      check(sectorProtect, 16'h0000);
      $display("test protect done");
   endtask : t_prot

   task automatic t_erase();
      int t0;
      int dur;
      cmd(SFP_OP_CE_A, 8);
      check(busy, 0);
      cmd(SFP_OP_WREN, 8);
      cmd(SFP_OP_CE_B, 7);
      check(busy, 0);
      cmd(SFP_OP_CE_B, 12);
      check(busy, 0);
      cmd(SFP_OP_CE_A, 16);
      t0 = cyc;
      check(busy, 1);
      check(writeLatchFlag, 0);
      cmd(SFP_OP_WREN, 8);
      check(writeLatchFlag, 0);
      check(busy, 1);
      wait_idle(dur, t0);
      check(16'(dur >= ERASE_N - 10 && dur < ERASE_N), 16'h1);
      check(eraseProgramErrorFlag, 0);
      verifyFail = 1'b1;
      cmd(SFP_OP_WREN, 8);
      cmd(SFP_OP_CE_B, 8);
      t0 = cyc;
      check(busy, 1);
      wait_idle(dur, t0);
      check(eraseProgramErrorFlag, 1);
      verifyFail = 1'b0;
      $display("test erase done");
   endtask : t_erase

   // Mid-run reset must re-protect every sector and clear both flags
   task automatic t_rereset();
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      check(sectorProtect, 16'hffff);
      check(writeLatchFlag, 0);
      check(eraseProgramErrorFlag, 0);
      check(busy, 0);
      cmd(SFP_OP_WREN, 8);
      check(writeLatchFlag, 1);
      $display("test reset again done");
   endtask : t_rereset

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_latch();
      t_prot();
      t_erase();
      t_rereset();
      print_verdict();
   end
endmodule : test_sfp_sequencer

// ---- inc/sfp_pkg.sv ----
// Purpose: Shared constants and types of the flash command sequencer.
// Assumes: Opcodes arrive most significant bit first, one byte each.
// Notes:   Sector index comes from address bits starting at SFP_SECTOR_LSB.
package sfp_pkg;

   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] SFP_OP_WREN = 8'h06;
   localparam logic [7:0] SFP_OP_WRDI = 8'h04;
   localparam logic [7:0] SFP_OP_CE_A = 8'h60;
   localparam logic [7:0] SFP_OP_CE_B = 8'hc7;
   localparam logic [7:0] SFP_OP_PROT = 8'h36;
   localparam logic [7:0] SFP_OP_UNPROT = 8'h39;

   // ---------------------------------------------------------------
   // Framing and layout
   // ---------------------------------------------------------------
   localparam logic [2:0] SFP_BIT_LAST = 3'h7;
   localparam logic [2:0] SFP_ADDR_BYTES = 3'h3;
   localparam logic [2:0] SFP_FRAME_FULL = 3'h4;
   localparam int SFP_SECTOR_LSB = 16;
   localparam int SFP_NUM_SECTORS = 16;
   localparam int SFP_ERASE_CYCLES = 2000;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic SFP_PROT_RESET = 1'b1;
   localparam logic SFP_LATCH_RESET = 1'b0;
   localparam logic SFP_ERR_RESET = 1'b0;

   typedef enum logic [1:0] {
      SFP_IDLE = 2'b00,
      SFP_ERASE = 2'b01
   } sfp_state_type;

endpackage : sfp_pkg

// ---- inc/sfp_prot_if.sv ----
// Purpose: Carries protection updates between sequencer and bit bank.
// Assumes: One update request per cycle at most.
// Notes:   prot and anyProt are registered inside the bank.
interface sfp_prot_if #(
   parameter int NUM_SECTORS = 16,
   parameter int SECTOR_BITS = 4
);
   logic setReq;
   logic clrReq;
   logic [SECTOR_BITS-1:0] sectorIdx;
   logic [NUM_SECTORS-1:0] prot;
   logic anyProt;

   modport ctrl (output setReq, clrReq, sectorIdx, input prot, anyProt);
   modport bank (input setReq, clrReq, sectorIdx, output prot, anyProt);
endinterface : sfp_prot_if

// ---- rtl/sfp_prot_bank.sv ----
// Purpose: One protection bit per sector, all protected after reset.
// Assumes: Requests come from the sequencer on core_clk.
// Notes:   anyProt follows the bank in the same edge as the bits.
module sfp_prot_bank
   import sfp_pkg::*;
#(
   parameter int NUM_SECTORS = SFP_NUM_SECTORS
) (
   input wire logic core_clk,
   input wire logic rst,
   sfp_prot_if.bank bus
);
   logic [NUM_SECTORS-1:0] protQ;
   logic [NUM_SECTORS-1:0] protD;

   // ---------------------------------------------------------------
   // Bit bank
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_bit
      always_comb begin
         protD[i] = protQ[i];
         if (bus.setReq && bus.sectorIdx == i) begin
            protD[i] = 1'b1;
         end else if (bus.clrReq && bus.sectorIdx == i) begin
            protD[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         protQ <= {NUM_SECTORS{SFP_PROT_RESET}};
         bus.anyProt <= SFP_PROT_RESET;
      end else begin
         protQ <= protD;
         bus.anyProt <= |protD;
      end
   end

   assign bus.prot = protQ;

   reset_all_prot_a: assert property (@(posedge core_clk) disable iff (rst)
      $past(rst) |-> (&bus.prot && bus.anyProt))
      else $error("sectors not all protected after reset");

endmodule : sfp_prot_bank

// ---- rtl/sfp_sequencer.sv ----
// Purpose: Serial command decode for erase, write latch and protection.
// Assumes: Link pins are asynchronous; serial clock far below core_clk.
// Notes:   Commands act when chip select rises; busy blocks new ones.
//
// Contract
// - Whole erase needs write latch set first
// - Two erase opcodes, no address, trailing ignored
// - Erase starts on deselect, self-timed
// - Erase needs whole opcode, byte-aligned deselect
// - Any protected sector: skip erase, clear latch
// - Busy during erase; latch cleared before end
// - Erase failure sets error flag
// - Guarded commands run only with latch set
// - Write-enable sets latch on deselect
// - Write-disable clears latch on deselect
// - Misframed enable/disable leaves latch unchanged
// - One protect bit per sector, reset protected
// - Zero allows erase, one blocks it
// - Protect command sets sector bit, clears latch
// - Unprotect command clears sector bit, clears latch
// - Short protect frame: abort, clear latch
// - Lock bit: ignore protect commands, clear latch
// - Write-protect low with lock: hard-locked
module sfp_sequencer
   import sfp_pkg::*;
#(
   parameter int NUM_SECTORS = SFP_NUM_SECTORS,
   parameter int ERASE_CYCLES = SFP_ERASE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic chipSelN,
   input wire logic serialClk,
   input wire logic serialIn,
   input wire logic writeProtectN,
   input wire logic protectionLockBit,
   input wire logic verifyFail,
   output logic writeLatchFlag,
   output logic busy,
   output logic eraseProgramErrorFlag,
   output logic [NUM_SECTORS-1:0] sectorProtect
);
   localparam int SECTOR_BITS = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;
   localparam int TIMER_BITS = $clog2(ERASE_CYCLES + 1);
   localparam logic [TIMER_BITS-1:0] TIMER_LOAD =
      TIMER_BITS'(ERASE_CYCLES - 1);

   sfp_prot_if #(.NUM_SECTORS(NUM_SECTORS), .SECTOR_BITS(SECTOR_BITS))
      protBus ();

   sfp_prot_bank #(.NUM_SECTORS(NUM_SECTORS)) u_bank (
      .core_clk(core_clk),
      .rst(rst),
      .bus(protBus)
   );

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Bits: 3 chip select, 2 serial clock, 1 data, 0 write protect
   logic [3:0] pinQ1;
   logic [3:0] pinQ2;
   logic csPrevQ;
   logic sclkPrevQ;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pinQ1 <= 4'hf;
         pinQ2 <= 4'hf;
         csPrevQ <= 1'b1;
         sclkPrevQ <= 1'b1;
      end else begin
         pinQ1 <= {chipSelN, serialClk, serialIn, writeProtectN};
         pinQ2 <= pinQ1;
         csPrevQ <= pinQ2[3];
         sclkPrevQ <= pinQ2[2];
      end
   end

   logic csFall;
   logic csRise;
   logic sclkRise;
   assign csFall = csPrevQ && !pinQ2[3];
   assign csRise = !csPrevQ && pinQ2[3];
   assign sclkRise = !sclkPrevQ && pinQ2[2] && !pinQ2[3];

   // ---------------------------------------------------------------
   // Frame shifter
   // ---------------------------------------------------------------
   logic [7:0] shiftQ, shiftD;
   logic [2:0] bitCntQ, bitCntD;
   logic [2:0] byteCntQ, byteCntD;
   logic [7:0] opQ, opD;
   logic [23:0] addrQ, addrD;
   logic [7:0] newByte;

   assign newByte = {shiftQ[6:0], pinQ2[1]};

   always_comb begin
      shiftD = shiftQ;
      bitCntD = bitCntQ;
      byteCntD = byteCntQ;
      opD = opQ;
      addrD = addrQ;
      if (csFall) begin
         bitCntD = 3'h0;
         byteCntD = 3'h0;
      end else if (sclkRise) begin
         shiftD = newByte;
         bitCntD = bitCntQ + 3'h1;
         if (bitCntQ == SFP_BIT_LAST) begin
            if (byteCntQ == 3'h0) begin
               opD = newByte;
            end else if (byteCntQ <= SFP_ADDR_BYTES) begin
               addrD = {addrQ[15:0], newByte};
            end
            // Saturate so trailing bytes are ignored
            if (byteCntQ != SFP_FRAME_FULL) begin
               byteCntD = byteCntQ + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         shiftQ <= 8'h00;
         bitCntQ <= 3'h0;
         byteCntQ <= 3'h0;
         opQ <= 8'h00;
         addrQ <= 24'h000000;
      end else begin
         shiftQ <= shiftD;
         bitCntQ <= bitCntD;
         byteCntQ <= byteCntD;
         opQ <= opD;
         addrQ <= addrD;
      end
   end

   // ---------------------------------------------------------------
   // Command execution
   // ---------------------------------------------------------------
   logic aligned;
   logic hasOp;
   logic isErase;
   logic isProt;
   logic protLocked;
   logic [SECTOR_BITS-1:0] addrSector;

   assign aligned = bitCntQ == 3'h0;
   assign hasOp = byteCntQ != 3'h0;
   assign isErase = opQ == SFP_OP_CE_A || opQ == SFP_OP_CE_B;
   assign isProt = opQ == SFP_OP_PROT || opQ == SFP_OP_UNPROT;
   // Hard lock implies soft lock, so both close the same door
   assign protLocked = protectionLockBit ||
      (protectionLockBit && !pinQ2[0]);
   assign addrSector = addrQ[SFP_SECTOR_LSB +: SECTOR_BITS];

   sfp_state_type stateQ, stateD;
   logic latchQ, latchD;
   logic errQ, errD;
   logic busyQ, busyD;
   logic [TIMER_BITS-1:0] timerQ, timerD;
   logic setReqQ, setReqD;
   logic clrReqQ, clrReqD;
   logic [SECTOR_BITS-1:0] idxQ, idxD;

   always_comb begin
      stateD = stateQ;
      latchD = latchQ;
      errD = errQ;
      busyD = busyQ;
      timerD = timerQ;
      setReqD = 1'b0;
      clrReqD = 1'b0;
      idxD = idxQ;
      case (stateQ)
         SFP_IDLE: begin
            if (csRise && hasOp) begin
               if (opQ == SFP_OP_WREN && aligned) begin
                  latchD = 1'b1;
               end else if (opQ == SFP_OP_WRDI && aligned) begin
                  latchD = 1'b0;
               end else if (isErase && aligned && latchQ) begin
                  latchD = 1'b0;
                  if (!protBus.anyProt) begin
                     stateD = SFP_ERASE;
                     busyD = 1'b1;
                     errD = 1'b0;
                     timerD = TIMER_LOAD;
                  end
               end else if (isProt && latchQ) begin
                  latchD = 1'b0;
                  if (!protLocked && aligned &&
                      byteCntQ == SFP_FRAME_FULL) begin
                     setReqD = opQ == SFP_OP_PROT;
                     clrReqD = opQ == SFP_OP_UNPROT;
                     idxD = addrSector;
                  end
               end
            end
         end
         SFP_ERASE: begin
            // Runs on core_clk alone, no serial clock needed
            if (verifyFail) begin
               errD = 1'b1;
            end
            if (timerQ == '0) begin
               stateD = SFP_IDLE;
               busyD = 1'b0;
            end else begin
               timerD = timerQ - TIMER_BITS'(1);
            end
         end
         default: begin
            stateD = SFP_IDLE;
            busyD = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stateQ <= SFP_IDLE;
         latchQ <= SFP_LATCH_RESET;
         errQ <= SFP_ERR_RESET;
         busyQ <= 1'b0;
         timerQ <= '0;
         setReqQ <= 1'b0;
         clrReqQ <= 1'b0;
         idxQ <= '0;
      end else begin
         stateQ <= stateD;
         latchQ <= latchD;
         errQ <= errD;
         busyQ <= busyD;
         timerQ <= timerD;
         setReqQ <= setReqD;
         clrReqQ <= clrReqD;
         idxQ <= idxD;
      end
   end

   assign protBus.setReq = setReqQ;
   assign protBus.clrReq = clrReqQ;
   assign protBus.sectorIdx = idxQ;

   assign writeLatchFlag = latchQ;
   assign busy = busyQ;
   assign eraseProgramErrorFlag = errQ;
   assign sectorProtect = protBus.prot;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic endIdle;
   assign endIdle = csRise && hasOp && !busyQ;

   sequence eraseRun;
      (busyQ && !latchQ) [*8];
   endsequence

   sequence protUntouched;
      $stable(protBus.prot) ##1 $stable(protBus.prot);
   endsequence

   wren_sets_a: assert property (
      endIdle && aligned && opQ == SFP_OP_WREN |=> latchQ)
      else $error("write enable did not set latch");

   wrdi_clears_a: assert property (
      endIdle && aligned && opQ == SFP_OP_WRDI |=> !latchQ)
      else $error("write disable did not clear latch");

   misframe_hold_a: assert property (
      endIdle && !aligned &&
      (opQ == SFP_OP_WREN || opQ == SFP_OP_WRDI) |=> $stable(latchQ))
      else $error("misframed enable changed latch");

   no_latch_a: assert property (
      endIdle && !latchQ |=> (!busyQ and protUntouched))
      else $error("guarded command ran without latch");

   erase_start_a: assert property (
      endIdle && aligned && isErase && latchQ && !protBus.anyProt
      |=> eraseRun)
      else $error("erase did not start or hold busy");

   erase_skip_a: assert property (
      endIdle && aligned && isErase && latchQ && protBus.anyProt
      |=> !busyQ && !latchQ)
      else $error("erase ran with a protected sector");

   erase_partial_a: assert property (
      endIdle && isErase && !aligned |=> !busyQ)
      else $error("misaligned erase started");

   prot_set_a: assert property (
      endIdle && aligned && byteCntQ == SFP_FRAME_FULL && latchQ &&
      opQ == SFP_OP_PROT && !protLocked
      |=> !latchQ ##1 protBus.prot[idxQ])
      else $error("protect command missed its sector");

   unprot_clr_a: assert property (
      endIdle && aligned && byteCntQ == SFP_FRAME_FULL && latchQ &&
      opQ == SFP_OP_UNPROT && !protLocked
      |=> !latchQ ##1 !protBus.prot[idxQ])
      else $error("unprotect command missed its sector");

   lock_ignore_a: assert property (
      endIdle && isProt && latchQ && protLocked
      |=> (!latchQ and protUntouched))
      else $error("locked bank was changed");

   short_addr_a: assert property (
      endIdle && isProt && latchQ &&
      (!aligned || byteCntQ != SFP_FRAME_FULL)
      |=> (!latchQ and protUntouched))
      else $error("short protect frame changed bank");

   fail_flag_a: assert property (
      busyQ && verifyFail |=> errQ)
      else $error("erase failure not flagged");

endmodule : sfp_sequencer
